//--- design/pcdpc_map.vh
// Register offsets, field positions and reset values for port containment
`ifndef PCDPC_MAP_VH
`define PCDPC_MAP_VH

// ==========================================================
// Register word offsets (byte addresses, 32-bit words)
`define PCDPC_OFS_CAPCTL 12'h254
`define PCDPC_OFS_STATUS 12'h258

// ==========================================================
// Capability half (low 16 bits of word 254h)
`define PCDPC_VEC_LSB 0
`define PCDPC_VEC_MSB 4
`define PCDPC_VEC_RESET 5'h01

// ==========================================================
// Control half (high 16 bits of word 254h)
`define PCDPC_TSEL_LSB 16
`define PCDPC_TSEL_MSB 17
`define PCDPC_CPLSEL_BIT 18
`define PCDPC_IRQEN_BIT 19
`define PCDPC_CORMSG_BIT 20

// ==========================================================
// Status half (low 16 bits of word 258h) and source id (high half)
`define PCDPC_TRIG_BIT 0
`define PCDPC_CAUSE_LSB 1
`define PCDPC_CAUSE_MSB 2
`define PCDPC_IRQPEND_BIT 3
`define PCDPC_SRC_LSB 16
`define PCDPC_SRC_MSB 31
`define PCDPC_SRC_RESET 16'h0000

// ==========================================================
// Encodings
`define PCDPC_TSEL_OFF 2'h0
`define PCDPC_TSEL_FATAL 2'h1
`define PCDPC_TSEL_ALL 2'h2
`define PCDPC_CAUSE_UNCOR 2'h0
`define PCDPC_CAUSE_NONFATAL 2'h1
`define PCDPC_CAUSE_FATAL 2'h2
`define PCDPC_CPL_CA 3'h4
`define PCDPC_CPL_UR 3'h1

`endif

//--- design/pcdpc_port_containment.v
// Downstream port containment control and status logic
//
// Notes on behaviour
// - Trigger select zero disables containment; field resets to zero.
// - Select one triggers on uncorrectable error or ERR_FATAL, not ERR_NONFATAL.
// - Select two also triggers on ERR_NONFATAL; value three is reserved.
// - Contained completions use CA status when bit 18 clear, UR when set.
// - Containment interrupt raised only when bit 19 is set.
// - ERR_COR message sent only when bit 20 is set.
// - Triggered bit sets on trigger, cleared by writing one.
// - Cause field records uncorrectable, nonfatal or fatal; cleared by writing ones.
// - Interrupt pending sets on trigger with enable set; write one clears.
// - Requester ID of triggering message captured in read-only bits 31:16.
// - Interrupt uses read-only five-bit vector, reset value one.
`timescale 1ns/1ps
`include "pcdpc_map.vh"

module pcdpc_port_containment #(
  parameter [4:0] IRQ_VECTOR = `PCDPC_VEC_RESET
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  // Error event inputs, one-cycle pulses
  input wire uncor_err,
  input wire err_fatal_rx,
  input wire err_nonfatal_rx,
  input wire [15:0] msg_requester_id,
  // Register read data
  output reg [31:0] reg_rdata,
  // Containment outputs
  output reg containment_active,
  output reg [2:0] contained_cpl_status,
  output reg containment_irq,
  output reg [4:0] containment_irq_vector,
  output reg containment_correctable_msg
);

  // ==========================================================
  // Storage
  reg [1:0] containment_trigger_select_reg;
  reg contained_completion_status_select_reg;
  reg containment_irq_enable_reg;
  reg containment_correctable_msg_enable_reg;
  reg containment_triggered_reg;
  reg [1:0] containment_cause_reg;
  reg containment_irq_pending_reg;
  reg [15:0] containment_source_requester_reg;

  // ==========================================================
  // Trigger decode
  reg trig_fire;
  reg [1:0] trig_cause;
  wire wr_ctl;
  wire wr_sts;
  wire clr_trig;
  wire clr_irq;
  wire clr_cause;

  assign wr_ctl = reg_wr && (reg_addr == `PCDPC_OFS_CAPCTL);
  assign wr_sts = reg_wr && (reg_addr == `PCDPC_OFS_STATUS);
  assign clr_trig = wr_sts && reg_wdata[`PCDPC_TRIG_BIT];
  assign clr_irq = wr_sts && reg_wdata[`PCDPC_IRQPEND_BIT];
  assign clr_cause = wr_sts && (reg_wdata[`PCDPC_CAUSE_MSB:`PCDPC_CAUSE_LSB] == 2'h3);

  always @* begin
    trig_fire = 1'b0;
    trig_cause = `PCDPC_CAUSE_UNCOR;
    case (containment_trigger_select_reg)
      `PCDPC_TSEL_FATAL: begin
        // Nonfatal messages are ignored here
        if (uncor_err) begin
          trig_fire = 1'b1;
          trig_cause = `PCDPC_CAUSE_UNCOR;
        end else if (err_fatal_rx) begin
          trig_fire = 1'b1;
          trig_cause = `PCDPC_CAUSE_FATAL;
        end
      end
      `PCDPC_TSEL_ALL: begin
        // Fatal outranks nonfatal when both arrive together
        if (uncor_err) begin
          trig_fire = 1'b1;
          trig_cause = `PCDPC_CAUSE_UNCOR;
        end else if (err_fatal_rx) begin
          trig_fire = 1'b1;
          trig_cause = `PCDPC_CAUSE_FATAL;
        end else if (err_nonfatal_rx) begin
          trig_fire = 1'b1;
          trig_cause = `PCDPC_CAUSE_NONFATAL;
        end
      end
      default: begin
        // Disabled, and reserved value three behaves as disabled
        trig_fire = 1'b0;
        trig_cause = `PCDPC_CAUSE_UNCOR;
      end
    endcase
  end

  // ==========================================================
  // Control register
  always @(posedge clk) begin
    if (!rst_b) begin
      containment_trigger_select_reg <= `PCDPC_TSEL_OFF;
      contained_completion_status_select_reg <= 1'b0;
      containment_irq_enable_reg <= 1'b0;
      containment_correctable_msg_enable_reg <= 1'b0;
    end else if (wr_ctl) begin
      containment_trigger_select_reg <= reg_wdata[`PCDPC_TSEL_MSB:`PCDPC_TSEL_LSB];
      contained_completion_status_select_reg <= reg_wdata[`PCDPC_CPLSEL_BIT];
      containment_irq_enable_reg <= reg_wdata[`PCDPC_IRQEN_BIT];
      containment_correctable_msg_enable_reg <= reg_wdata[`PCDPC_CORMSG_BIT];
    end
  end

  // ==========================================================
  // Status register, set wins over clear
  always @(posedge clk) begin
    if (!rst_b) begin
      containment_triggered_reg <= 1'b0;
      containment_cause_reg <= `PCDPC_CAUSE_UNCOR;
      containment_irq_pending_reg <= 1'b0;
      containment_source_requester_reg <= `PCDPC_SRC_RESET;
    end else begin
      if (trig_fire) begin
        containment_triggered_reg <= 1'b1;
      end else if (clr_trig) begin
        containment_triggered_reg <= 1'b0;
      end
      if (trig_fire && !containment_triggered_reg) begin
        // First trigger records cause, and source only for a received message; later ones keep them
        containment_cause_reg <= trig_cause;
        if (trig_cause != `PCDPC_CAUSE_UNCOR) begin
          containment_source_requester_reg <= msg_requester_id;
        end
      end else if (clr_cause && !trig_fire) begin
        // A trigger beside the clear keeps the recorded cause
        containment_cause_reg <= `PCDPC_CAUSE_UNCOR;
      end
      if (trig_fire && containment_irq_enable_reg) begin
        containment_irq_pending_reg <= 1'b1;
      end else if (clr_irq) begin
        containment_irq_pending_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs and register read
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
      containment_active <= 1'b0;
      contained_cpl_status <= `PCDPC_CPL_CA;
      containment_irq <= 1'b0;
      containment_irq_vector <= `PCDPC_VEC_RESET;
      containment_correctable_msg <= 1'b0;
    end else begin
      containment_active <= containment_triggered_reg;
      if (contained_completion_status_select_reg) begin
        contained_cpl_status <= `PCDPC_CPL_UR;
      end else begin
        contained_cpl_status <= `PCDPC_CPL_CA;
      end
      containment_irq <= trig_fire && containment_irq_enable_reg;
      containment_irq_vector <= IRQ_VECTOR;
      containment_correctable_msg <= trig_fire && containment_correctable_msg_enable_reg;
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `PCDPC_OFS_CAPCTL: begin
            reg_rdata <= {11'h000, containment_correctable_msg_enable_reg,
              containment_irq_enable_reg, contained_completion_status_select_reg,
              containment_trigger_select_reg, 11'h000, IRQ_VECTOR};
          end
          `PCDPC_OFS_STATUS: begin
            reg_rdata <= {containment_source_requester_reg, 12'h000,
              containment_irq_pending_reg, containment_cause_reg,
              containment_triggered_reg};
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // pcdpc_port_containment

//--- tb/pcdpc_link_model.sv
// Far-end model: error detection and received error messages
`timescale 1ns/1ps
module pcdpc_link_model (
  // Clock
  input wire clk,
  // Error events toward the port
  output reg uncor_err,
  output reg err_fatal_rx,
  output reg err_nonfatal_rx,
  output reg [15:0] msg_requester_id
);
  initial {uncor_err, err_fatal_rx, err_nonfatal_rx, msg_requester_id} = 19'h0FFFF;
  // Kind follows the cause code: 0 uncorrectable, 1 nonfatal, 2 fatal
  task send(input [1:0] kind, input [15:0] id, input integer gap);
    begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      {err_fatal_rx, err_nonfatal_rx, uncor_err} <= {kind == 2'h2, kind == 2'h1, kind == 2'h0};
      msg_requester_id <= id;
      @(posedge clk);
      {err_fatal_rx, err_nonfatal_rx, uncor_err} <= 3'h0;
      // Released id shows no stale value
      msg_requester_id <= ~id;
    end
  endtask
endmodule // pcdpc_link_model

//--- tb/pcdpc_port_containment_tb.sv
// Self-checking testbench for port containment
`timescale 1ns/1ps
module pcdpc_port_containment_tb;
  reg clk;
  reg rst_b;
  reg [11:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr, reg_rd;
  wire uncor_err, err_fatal_rx, err_nonfatal_rx;
  wire [15:0] msg_requester_id;
  wire [31:0] reg_rdata;
  wire containment_active, containment_irq, containment_correctable_msg;
  wire [2:0] contained_cpl_status;
  wire [4:0] containment_irq_vector;
  integer errors, samples_checked, cycles;
  pcdpc_link_model i_pcdpc_link_model (.clk(clk), .uncor_err(uncor_err),
    .err_fatal_rx(err_fatal_rx), .err_nonfatal_rx(err_nonfatal_rx),
    .msg_requester_id(msg_requester_id));
  pcdpc_port_containment i_pcdpc_port_containment (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .uncor_err(uncor_err), .err_fatal_rx(err_fatal_rx), .err_nonfatal_rx(err_nonfatal_rx),
    .msg_requester_id(msg_requester_id), .reg_rdata(reg_rdata),
    .containment_active(containment_active),
    .contained_cpl_status(contained_cpl_status), .containment_irq(containment_irq),
    .containment_irq_vector(containment_irq_vector),
    .containment_correctable_msg(containment_correctable_msg));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      test_done;
    end
  end
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task check(input [8*28-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, exp);
    end
  endtask
  initial begin
    {errors, samples_checked, cycles} = 96'h0;
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = 47'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h254, 32'h0000_0001);
    rd(12'h258, 32'h0000_0000);
    $display("test reset_values done");
    i_pcdpc_link_model.send(2'h2, 16'h1234, 0);
    wr(12'h254, 32'h0003_0000);
    i_pcdpc_link_model.send(2'h0, 16'h1234, 2);
    wr(12'h254, 32'h001D_0000);
    rd(12'h254, 32'h001D_0001);
    check("contained_cpl_status", {29'h0, contained_cpl_status}, 32'h1);
    check("containment_irq_vector", {27'h0, containment_irq_vector}, 32'h1);
    i_pcdpc_link_model.send(2'h1, 16'h5A5A, 0);
    rd(12'h258, 32'h0000_0000);
    $display("test no_trigger done");
    i_pcdpc_link_model.send(2'h2, 16'hA5C3, 1);
    #1;
    check("containment_irq", {31'h0, containment_irq}, 32'h1);
    check("containment_correctable_msg", {31'h0, containment_correctable_msg}, 32'h1);
    rd(12'h258, 32'hA5C3_000D);
    check("containment_active", {31'h0, containment_active}, 32'h1);
    i_pcdpc_link_model.send(2'h0, 16'h0F0F, 0);
    wr(12'h258, 32'h0000_0000);
    rd(12'h258, 32'hA5C3_000D);
    wr(12'h258, 32'h0000_000F);
    rd(12'h258, 32'hA5C3_0000);
    check("containment_active", {31'h0, containment_active}, 32'h0);
    $display("test fatal_trigger done");
    wr(12'h254, 32'h0002_001F);
    i_pcdpc_link_model.send(2'h1, 16'h3C01, 0);
    #1;
    check("containment_irq", {31'h0, containment_irq}, 32'h0);
    check("contained_cpl_status", {29'h0, contained_cpl_status}, 32'h4);
    rd(12'h258, 32'h3C01_0003);
    wr(12'h258, 32'h0000_000F);
    i_pcdpc_link_model.send(2'h0, 16'hFFFF, 0);
    rd(12'h258, 32'h3C01_0001);
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300, 32'h0000_0000);
    rd(12'h254, 32'h0002_0001);
    $display("test nonfatal_trigger done");
    test_done;
  end
endmodule // pcdpc_port_containment_tb

//--- tb/pcdpc_properties.sv
// Assertion checker for port containment outputs
`timescale 1ns/1ps
module pcdpc_checker (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Events and outputs
  input wire uncor_err,
  input wire err_fatal_rx,
  input wire err_nonfatal_rx,
  input wire [2:0] contained_cpl_status,
  input wire containment_irq,
  input wire [4:0] containment_irq_vector,
  input wire containment_correctable_msg,
  input wire containment_active
);
  // =========================================
  // Shadow of control bits 20:16
  reg [4:0] ctl_reg;
  wire [1:0] tsel = ctl_reg[1:0];
  wire fire = (tsel == 2'h1 || tsel == 2'h2) &&
    (uncor_err || err_fatal_rx || (tsel == 2'h2 && err_nonfatal_rx));
  always @(posedge clk) begin
    if (!rst_b) ctl_reg <= 5'h00;
    else if (reg_wr && reg_addr == 12'h254) ctl_reg <= reg_wdata[20:16];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_fire; fire; endsequence
  property p_quiet; !fire |=> !containment_irq && !containment_correctable_msg; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without trigger");
  property p_irq; s_fire ##0 ctl_reg[3] |=> containment_irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_no_irq; !ctl_reg[3] |=> !containment_irq; endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled");
  property p_cor; s_fire ##0 ctl_reg[4] |=> containment_correctable_msg; endproperty
  a_cor: assert property (p_cor) else $error("correctable message missing");
  property p_no_cor; !ctl_reg[4] |=> !containment_correctable_msg; endproperty
  a_no_cor: assert property (p_no_cor) else $error("correctable while disabled");
  property p_active; s_fire |=> ##1 containment_active; endproperty
  a_active: assert property (p_active) else $error("containment not active");
  property p_cpl; contained_cpl_status == ($past(ctl_reg[2]) ? 3'h1 : 3'h4); endproperty
  a_cpl: assert property (p_cpl) else $error("completion status wrong");
  property p_vec; containment_irq_vector == 5'h01; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_rd_ctl;
    reg_rd && reg_addr == 12'h254 |=> reg_rdata == {11'h000, $past(ctl_reg), 11'h000, 5'h01};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
endmodule // pcdpc_checker

bind pcdpc_port_containment pcdpc_checker i_pcdpc_checker (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .uncor_err(uncor_err), .err_fatal_rx(err_fatal_rx),
  .err_nonfatal_rx(err_nonfatal_rx), .contained_cpl_status(contained_cpl_status),
  .containment_irq(containment_irq), .containment_irq_vector(containment_irq_vector),
  .containment_correctable_msg(containment_correctable_msg),
  .containment_active(containment_active));
